// ---- hdrs_defs.svh ----
/*
  constants of the headset detect result and status block: register offsets,
  field positions, reset values, binning step and timing.
  assumes it is included by bare name wherever a figure is needed.
*/
`ifndef HDRS_DEFS_SVH
`define HDRS_DEFS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define HDRS_OFS_RESULT   8'h05
`define HDRS_OFS_FLAGS    8'h06
`define HDRS_OFS_MASKS    8'h07

// ----------------------------------------
// reset values and writable bits
// ----------------------------------------
`define HDRS_RST_RESULT   8'h00
`define HDRS_RST_FLAGS    8'h00
`define HDRS_RST_MASKS    8'h00
`define HDRS_WMASK_RESULT 8'h7f
`define HDRS_WMASK_MASKS  8'h1b
`define HDRS_FLAG_BITS    8'h0b

// ----------------------------------------
// field positions
// ----------------------------------------
`define HDRS_GND_BIT      6
`define HDRS_TS_LSB       3
`define HDRS_TR_LSB       0
`define HDRS_ERR_BIT      3
`define HDRS_MIC_BIT      1
`define HDRS_TSR_BIT      0
`define HDRS_TRI_BIT      4

// ----------------------------------------
// impedance binning and timing
// ----------------------------------------
`define HDRS_BIN_OHMS     400
`define HDRS_BIN_COUNT    7
`define HDRS_TRIG_DELAY_MS 120
`define HDRS_CLK_NS       8

`endif

// ---- hdrs_pkg.sv ----
/*
  types of the headset detect result and status block.
  assumes nothing of its surroundings.
*/
`default_nettype none

package hdrs_pkg;

  // ----------------------------------------
  // sequence states and measured band pairs
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_WAIT, ST_MEAS_TS, ST_MEAS_TR, ST_MEAS_RS, ST_DECIDE
  } hdrs_state_t;

  typedef enum logic [1:0] {
    PAIR_TS, PAIR_TR, PAIR_RS
  } hdrs_pair_t;

  // ----------------------------------------
  // switch drive and result layout
  // ----------------------------------------
  typedef struct packed {
    logic mic_sleeve;
    logic mic_ring2;
    logic gnd_sleeve;
    logic gnd_ring2;
  } hdrs_switch_t;

  typedef struct packed {
    logic       rsvd;
    logic       ground_band_location;
    logic [2:0] tip_sleeve_impedance_code;
    logic [2:0] tip_ring2_impedance_code;
  } hdrs_result_t;

endpackage

`default_nettype wire

// ---- hdrs_zbin.sv ----
/*
  impedance binner: turns a measured resistance in ohms into a 3-bit code
  in 400 ohm bins, saturating at code 7.
  assumes the ohms value is stable while it is sampled by the caller.
*/
`default_nettype none
`include "hdrs_defs.svh"

module hdrs_zbin
  import hdrs_pkg::*;
(
  input  wire logic [13:0] ohms_i,
  output logic      [2:0]  code_o
);

  logic [`HDRS_BIN_COUNT-1:0] above;

  // ----------------------------------------
  // one comparator per bin edge
  // ----------------------------------------
  for (genvar k = 0; k < `HDRS_BIN_COUNT; k++) begin : g_edge
    assign above[k] = ohms_i >= 14'((k + 1) * `HDRS_BIN_OHMS);
  end

  // thermometer count gives the bin
  always_comb begin
    code_o = 3'h0;
    for (int k = 0; k < `HDRS_BIN_COUNT; k++) begin
      code_o = code_o + {2'h0, above[k]};
    end
  end

endmodule // hdrs_zbin

`default_nettype wire

// ---- hdrs_status.sv ----
/*
  headset detect result and status: detection sequence, result and flag
  registers, mask register, switch routing and the open-drain indicator.
  assumes a decoded register port from the serial slave, an analog front end
  that measures one band pair per request, and a pull-up on the indicator.
*/
`default_nettype none
`include "hdrs_defs.svh"

module hdrs_status
  import hdrs_pkg::*;
#(
  parameter int unsigned DELAY_CYCLES = (`HDRS_TRIG_DELAY_MS * 1000000) / `HDRS_CLK_NS
)(
  input  wire logic         CLOCK_I,
  input  wire logic         ARST_N_I,
  input  wire logic [7:0]   REG_ADDR_I,
  input  wire logic         REG_WR_I,
  input  wire logic [7:0]   REG_WDATA_I,
  output logic      [7:0]   REG_RDATA_O,
  input  wire logic         TRIG_PIN_I,
  input  wire logic         TRIG_PIN_DIS_I,
  input  wire logic         TRIG_REG_I,
  input  wire logic         AUTO_SWITCH_DISABLE_I,
  input  wire logic         INT_SEL_I,
  output logic              MEAS_REQ_O,
  output hdrs_pair_t        MEAS_PAIR_O,
  input  wire logic         MEAS_DONE_I,
  input  wire logic [13:0]  MEAS_OHMS_I,
  output hdrs_switch_t      SWITCH_O,
  output logic              BUSY_O,
  input  wire logic         MIC_IND_I,
  output logic              MIC_IND_O,
  output logic              MIC_IND_OE_O
);

  hdrs_state_t  state, next_state;
  logic [23:0]  cnt, next_cnt;
  logic [2:0]   ts_code, next_ts_code;
  logic [2:0]   tr_code, next_tr_code;
  logic [2:0]   rs_code, next_rs_code;
  logic         trig_prev;
  logic         trig_rise;
  logic [2:0]   bin_code;
  hdrs_result_t result, next_result, dec_result;
  logic [7:0]   flags, next_flags, dec_flags;
  logic [7:0]   masks, next_masks;
  logic [7:0]   rdata, next_rdata;
  hdrs_switch_t sw, next_sw, dec_sw;
  logic         ind_oe, next_ind_oe;
  logic         shorted;

  // ----------------------------------------
  // impedance binning
  // ----------------------------------------
  hdrs_zbin u_zbin (
    .ohms_i (MEAS_OHMS_I),
    .code_o (bin_code)
  );

  // ----------------------------------------
  // detection sequence
  // ----------------------------------------

  // pin trigger is edge sensitive and can be disabled
  assign trig_rise = TRIG_PIN_I & ~trig_prev & ~TRIG_PIN_DIS_I;

  // next state: trigger, delay after a pin trigger, three measurement steps, decision
  always_comb begin
    next_state   = state;
    next_cnt     = cnt;
    next_ts_code = ts_code;
    next_tr_code = tr_code;
    next_rs_code = rs_code;
    case (state)
      ST_IDLE: begin
        next_cnt = 24'h000000;
        if (TRIG_REG_I) begin
          next_state = ST_MEAS_TS;
        end else if (trig_rise) begin
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (cnt == 24'(DELAY_CYCLES - 1)) begin
          next_state = ST_MEAS_TS;
        end else begin
          next_cnt = cnt + 24'h000001;
        end
      end
      ST_MEAS_TS: begin
        if (MEAS_DONE_I) begin
          next_ts_code = bin_code;
          next_state   = ST_MEAS_TR;
        end
      end
      ST_MEAS_TR: begin
        if (MEAS_DONE_I) begin
          next_tr_code = bin_code;
          next_state   = ST_MEAS_RS;
        end
      end
      ST_MEAS_RS: begin
        if (MEAS_DONE_I) begin
          next_rs_code = bin_code;
          next_state   = ST_DECIDE;
        end
      end
      ST_DECIDE: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // sequence registers
  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      state     <= ST_IDLE;
      cnt       <= 24'h000000;
      ts_code   <= 3'h0;
      tr_code   <= 3'h0;
      rs_code   <= 3'h0;
      trig_prev <= 1'b0;
    end else begin
      state     <= next_state;
      cnt       <= next_cnt;
      ts_code   <= next_ts_code;
      tr_code   <= next_tr_code;
      rs_code   <= next_rs_code;
      trig_prev <= TRIG_PIN_I;
    end
  end

  // front end request follows the measuring states
  always_comb begin
    MEAS_REQ_O  = 1'b1;
    MEAS_PAIR_O = PAIR_TS;
    case (state)
      ST_MEAS_TS: MEAS_PAIR_O = PAIR_TS;
      ST_MEAS_TR: MEAS_PAIR_O = PAIR_TR;
      ST_MEAS_RS: MEAS_PAIR_O = PAIR_RS;
      default:    MEAS_REQ_O  = 1'b0;
    endcase
  end

  // ----------------------------------------
  // classification
  // ----------------------------------------

  // ground band shows a speaker-level impedance, the microphone band a higher one
  always_comb begin
    shorted    = rs_code == 3'h0;
    dec_result = hdrs_result_t'(`HDRS_RST_RESULT);
    dec_result.tip_sleeve_impedance_code = ts_code;
    dec_result.tip_ring2_impedance_code  = tr_code;
    dec_flags  = `HDRS_RST_FLAGS;
    dec_sw     = '0;
    if (shorted) begin
      dec_flags[`HDRS_TSR_BIT] = 1'b1;
      dec_result.ground_band_location = 1'b1;
      dec_sw.gnd_sleeve = 1'b1;
      dec_sw.gnd_ring2  = 1'b1;
    end else if (ts_code == 3'h0 && tr_code != 3'h0) begin
      dec_flags[`HDRS_MIC_BIT] = 1'b1;
      dec_result.ground_band_location = 1'b1;
      dec_sw.mic_ring2  = 1'b1;
      dec_sw.gnd_sleeve = 1'b1;
    end else if (tr_code == 3'h0 && ts_code != 3'h0) begin
      dec_flags[`HDRS_MIC_BIT] = 1'b1;
      dec_result.ground_band_location = 1'b0;
      dec_sw.mic_sleeve = 1'b1;
      dec_sw.gnd_ring2  = 1'b1;
    end else begin
      dec_flags[`HDRS_ERR_BIT] = 1'b1;
    end
  end

  // ----------------------------------------
  // registers, switches and indicator
  // ----------------------------------------

  // software writes, hardware updates at decision, read mux
  always_comb begin
    next_result = result;
    next_flags  = flags;
    next_masks  = masks;
    next_sw     = sw;
    if (REG_WR_I && REG_ADDR_I == `HDRS_OFS_RESULT) begin
      next_result = hdrs_result_t'(REG_WDATA_I & `HDRS_WMASK_RESULT);
    end
    if (REG_WR_I && REG_ADDR_I == `HDRS_OFS_MASKS) begin
      next_masks = REG_WDATA_I & `HDRS_WMASK_MASKS;
    end
    if (state == ST_IDLE && next_state != ST_IDLE) begin
      next_flags = `HDRS_RST_FLAGS;
    end
    if (state == ST_DECIDE) begin
      next_result = dec_result;
      next_flags  = dec_flags;
      if (!AUTO_SWITCH_DISABLE_I) begin
        next_sw = dec_sw;
      end
    end
    case (REG_ADDR_I)
      `HDRS_OFS_RESULT: next_rdata = result;
      `HDRS_OFS_FLAGS:  next_rdata = flags;
      `HDRS_OFS_MASKS:  next_rdata = masks;
      default:          next_rdata = 8'h00;
    endcase
    if (masks[`HDRS_TRI_BIT]) begin
      next_ind_oe = 1'b0;
    end else if (INT_SEL_I) begin
      next_ind_oe = |(flags & ~masks & `HDRS_FLAG_BITS);
    end else begin
      next_ind_oe = flags[`HDRS_MIC_BIT];
    end
  end

  // register bank
  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      result <= hdrs_result_t'(`HDRS_RST_RESULT);
      flags  <= `HDRS_RST_FLAGS;
      masks  <= `HDRS_RST_MASKS;
      rdata  <= 8'h00;
      sw     <= '0;
      ind_oe <= 1'b0;
    end else begin
      result <= next_result;
      flags  <= next_flags;
      masks  <= next_masks;
      rdata  <= next_rdata;
      sw     <= next_sw;
      ind_oe <= next_ind_oe;
    end
  end

  // open drain: only ever pulls low
  assign REG_RDATA_O  = rdata;
  assign SWITCH_O     = sw;
  assign BUSY_O       = state != ST_IDLE;
  assign MIC_IND_O    = 1'b0;
  assign MIC_IND_OE_O = ind_oe;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic        ever_done;
  logic [23:0] wait_len;

  // remembers that a detection or a write has touched the result
  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ever_done <= 1'b0;
    end else if (state == ST_DECIDE || (REG_WR_I && REG_ADDR_I == `HDRS_OFS_RESULT)) begin
      ever_done <= 1'b1;
    end
  end

  // counts the cycles spent waiting after a pin trigger, cleared in idle
  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      wait_len <= 24'h000000;
    end else if (state == ST_WAIT) begin
      wait_len <= wait_len + 24'h000001;
    end else if (state == ST_IDLE) begin
      wait_len <= 24'h000000;
    end
  end

  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!ARST_N_I);

  a_result_before_det: assert property (!ever_done |-> result == 8'h00)
    else $error("result not zero before detection");
  a_flags_read_only: assert property (
      REG_WR_I && REG_ADDR_I == `HDRS_OFS_FLAGS && state == ST_IDLE
      && !TRIG_REG_I && !trig_rise |=> $stable(flags))
    else $error("status flags changed by write");
  a_delay_full: assert property (
      state == ST_MEAS_TS && $past(state) == ST_WAIT |-> wait_len == 24'(DELAY_CYCLES))
    else $error("trigger delay not its full length");
  a_decide_after_steps: assert property (state == ST_DECIDE |-> $past(state) == ST_MEAS_RS)
    else $error("decision without all steps");
  a_ts_bin: assert property (
      state == ST_MEAS_TS && MEAS_DONE_I && MEAS_OHMS_I >= 14'd2800 |=> ts_code == 3'h7)
    else $error("tip-sleeve code not saturated");
  a_tr_bin: assert property (
      state == ST_MEAS_TR && MEAS_DONE_I && MEAS_OHMS_I < 14'd400 |=> tr_code == 3'h0)
    else $error("tip-ring2 low code wrong");
  a_err_alone: assert property (flags[`HDRS_ERR_BIT] |-> !flags[`HDRS_MIC_BIT] && !flags[`HDRS_TSR_BIT])
    else $error("error flag with a found plug");
  a_gnd_routing: assert property (
      state == ST_DECIDE && !AUTO_SWITCH_DISABLE_I && flags == 8'h00
      ##1 flags[`HDRS_MIC_BIT] |-> sw.gnd_sleeve == result.ground_band_location
      && sw.mic_ring2 == result.ground_band_location)
    else $error("ground and microphone routing disagree with result");
  a_mic_routing: assert property (
      state == ST_DECIDE && !AUTO_SWITCH_DISABLE_I ##1 flags[`HDRS_MIC_BIT]
      |-> (sw.mic_ring2 ^ sw.mic_sleeve) && (sw.gnd_ring2 ^ sw.gnd_sleeve) && sw.mic_ring2 == sw.gnd_sleeve)
    else $error("microphone not routed to one band opposite ground");
  a_three_band_gnd: assert property (
      state == ST_DECIDE && !AUTO_SWITCH_DISABLE_I ##1 flags[`HDRS_TSR_BIT]
      |-> sw.gnd_ring2 && sw.gnd_sleeve && !sw.mic_ring2 && !sw.mic_sleeve)
    else $error("three-band plug not grounded on both bands");
  a_reserved_zero: assert property (
      result.rsvd == 1'b0 && (flags & ~`HDRS_FLAG_BITS) == 8'h00 && (masks & ~`HDRS_WMASK_MASKS) == 8'h00)
    else $error("reserved bit set");
  a_auto_disabled: assert property (state == ST_DECIDE && AUTO_SWITCH_DISABLE_I |=> $stable(sw))
    else $error("switches moved while auto switching disabled");
  a_tristate_mask: assert property (masks[`HDRS_TRI_BIT] |=> !MIC_IND_OE_O)
    else $error("indicator driven while tri-stated");
  a_masked_quiet: assert property (
      INT_SEL_I && !masks[`HDRS_TRI_BIT]
      && (flags & ~masks & `HDRS_FLAG_BITS) == 8'h00 |=> !MIC_IND_OE_O)
    else $error("masked flag reached indicator");
  a_unmasked_low: assert property (
      INT_SEL_I && !masks[`HDRS_TRI_BIT]
      && (flags & ~masks & `HDRS_FLAG_BITS) != 8'h00 |=> MIC_IND_OE_O)
    else $error("unmasked flag did not pull indicator");

  c_mic_found: cover property (state == ST_DECIDE ##1 flags[`HDRS_MIC_BIT]);
  c_three_band: cover property (state == ST_DECIDE ##1 flags[`HDRS_TSR_BIT]);
  c_detection_failed_flag: cover property (state == ST_DECIDE ##1 flags[`HDRS_ERR_BIT]);
  c_pin_start: cover property (state == ST_WAIT ##1 state == ST_MEAS_TS);

endmodule // hdrs_status

`default_nettype wire

// ---- hdrs_fe_model.sv ----
/*
  analog front end model: answers each measurement request with one done
  pulse carrying the ohms of the requested band pair after a set latency.
  assumes requests are sampled on the falling edge of the clock.
*/
`default_nettype none

module hdrs_fe_model
  import hdrs_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        req_i,
  input  wire hdrs_pair_t  pair_i,
  input  wire logic [13:0] ts_i,
  input  wire logic [13:0] tr_i,
  input  wire logic [13:0] rs_i,
  input  wire logic [3:0]  lat_i,
  output var  logic        done_o,
  output var  logic [13:0] ohms_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] cnt;

  initial begin
    done_o = 1'b0;
    ohms_o = 14'h0;
    cnt    = 4'h0;
  end

  // one pulse per request; ohms keep toggling whenever they are not valid
  always @(negedge clk_i) begin
    if (done_o || !req_i) begin
      done_o <= 1'b0;
      ohms_o <= ~ohms_o;
      cnt    <= 4'h0;
    end else if (cnt >= lat_i) begin
      done_o <= 1'b1;
      ohms_o <= (pair_i == PAIR_TS) ? ts_i : (pair_i == PAIR_TR) ? tr_i : rs_i;
    end else begin
      cnt    <= cnt + 4'h1;
      ohms_o <= ~ohms_o;
    end
  end
endmodule // hdrs_fe_model

`default_nettype wire

// ---- hdrs_status_tb_top.sv ----
/*
  self-checking bench of the headset detect result and status block.
  assumes the front end model and a pull-up on the indicator pin.
*/
`default_nettype none

module hdrs_status_tb_top;
  import hdrs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // signals
  // ----------------------------------------
  localparam int DLY = 20;
  logic         clk, rst_n, wr, trig_pin, pin_dis, trig_reg, sw_dis, int_sel, done, req, busy, ind, ind_oe, pin_lvl;
  logic [7:0]   addr, wdata, rdata, mask_v;
  logic [13:0]  ohms, z_ts, z_tr, z_rs;
  logic [3:0]   lat, exp_sw;
  logic [31:0]  seed, rv;
  hdrs_pair_t   pair;
  hdrs_switch_t sw;
  int           err_count, cmp_count, cyc, tt[6], tr[6], ts[6];

  assign pin_lvl = ind_oe ? ind : 1'b1; // pull-up when released

  hdrs_status #(.DELAY_CYCLES(DLY)) uut (
    .CLOCK_I(clk), .ARST_N_I(rst_n), .REG_ADDR_I(addr), .REG_WR_I(wr), .REG_WDATA_I(wdata),
    .REG_RDATA_O(rdata), .TRIG_PIN_I(trig_pin), .TRIG_PIN_DIS_I(pin_dis), .TRIG_REG_I(trig_reg),
    .AUTO_SWITCH_DISABLE_I(sw_dis), .INT_SEL_I(int_sel), .MEAS_REQ_O(req), .MEAS_PAIR_O(pair),
    .MEAS_DONE_I(done), .MEAS_OHMS_I(ohms), .SWITCH_O(sw), .BUSY_O(busy),
    .MIC_IND_I(pin_lvl), .MIC_IND_O(ind), .MIC_IND_OE_O(ind_oe));

  hdrs_fe_model fe (.clk_i(clk), .req_i(req), .pair_i(pair), .ts_i(z_ts), .tr_i(z_tr),
    .rs_i(z_rs), .lat_i(lat), .done_o(done), .ohms_o(ohms));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr  = a;
    wdata = d;
    wr    = 1'b1;
    @(negedge clk);
    wr    = 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    addr = a;
    @(negedge clk);
    d = rdata;
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // one detection and the model's view of its outcome
  task automatic run(input int t, input int r, input int s, input bit pin);
    logic [7:0] d, ef, er;
    logic [3:0] ew;
    logic       eoe;
    int         ct, cr, cs, n;
    z_ts = 14'(t);
    z_tr = 14'(r);
    z_rs = 14'(s);
    ct = (t / 400 > 7) ? 7 : t / 400;
    cr = (r / 400 > 7) ? 7 : r / 400;
    cs = (s / 400 > 7) ? 7 : s / 400;
    @(negedge clk);
    n = 0;
    if (pin) begin
      trig_pin = 1'b1;
      while (!req && n < 100) begin
        @(negedge clk);
        n++;
      end
      chk("start delay", 8'(DLY + 1), 8'(n));
      trig_pin = 1'b0;
    end else begin
      trig_reg = 1'b1;
      @(negedge clk);
      trig_reg = 1'b0;
    end
    while (busy && n < 300) begin
      @(negedge clk);
      n++;
    end
    chk("sequence end", 8'h00, {7'h0, busy});
    if (cs == 0) begin
      ef = 8'h01; er = 8'h40; ew = 4'h3;
    end else if (ct == 0 && cr != 0) begin
      ef = 8'h02; er = 8'h40; ew = 4'h6;
    end else if (cr == 0 && ct != 0) begin
      ef = 8'h02; er = 8'h00; ew = 4'h9;
    end else begin
      ef = 8'h08; er = 8'h00; ew = 4'h0;
    end
    er = er | 8'((ct << 3) | cr);
    if (!sw_dis) exp_sw = ew;
    eoe = mask_v[4] ? 1'b0 : int_sel ? |(ef & ~mask_v & 8'h0b) : ef[1];
    rd_reg(8'h05, d);
    chk("result", er, d);
    rd_reg(8'h06, d);
    chk("flags", ef, d);
    chk("indicator", {7'h0, eoe}, {7'h0, ind_oe});
    chk("indicator pin", {7'h0, ~eoe}, {7'h0, pin_lvl});
    chk("switch", {4'h0, exp_sw}, {4'h0, sw});
  endtask

  // ----------------------------------------
  // clock, watchdog and sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // cuts a hang short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      $display("[FAIL] cycle limit expected %0d seen %0d", 19999, cyc);
      complete_run();
    end
  end

  initial begin
    logic [7:0] d;
    {rst_n, wr, trig_pin, pin_dis, trig_reg, sw_dis, int_sel, addr, wdata, lat, mask_v, exp_sw} = '0;
    {z_ts, z_tr, z_rs} = '0;
    seed = 32'd49272;
    tt = '{100, 399, 2800, 400, 16383, 0};
    tr = '{5000, 400, 0, 400, 16383, 0};
    ts = '{399, 3000, 3000, 400, 16383, 500};
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    foreach (tt[i]) begin
      rd_reg(8'h05 + 8'(i), d);
      chk("reset value", 8'h00, d);
    end
    chk("switch reset", 8'h00, {4'h0, sw});
    wr_reg(8'h07, 8'hff);
    rd_reg(8'h07, d);
    chk("masks", 8'h1b, d);
    wr_reg(8'h05, 8'hff);
    rd_reg(8'h05, d);
    chk("result write", 8'h7f, d);
    wr_reg(8'h06, 8'hff);
    rd_reg(8'h06, d);
    chk("flags write", 8'h00, d);
    $display("test registers done");
    pin_dis = 1'b1;
    trig_pin = 1'b1;
    repeat (4) @(negedge clk);
    chk("disabled pin", 8'h00, {7'h0, busy});
    trig_pin = 1'b0;
    pin_dis = 1'b0;
    mask_v = 8'h00;
    wr_reg(8'h07, 8'h00);
    run(399, 800, 2000, 1'b1);
    $display("test pin trigger done");
    for (int i = 0; i < 40; i++) begin
      rv = xs();
      if (i < 6) begin
        rv = {30'h0, i[0], 1'b0} << 7;
      end
      mask_v = rv[7:0] & 8'h1b;
      int_sel = rv[8];
      sw_dis = rv[9] & rv[10];
      lat = {2'b00, rv[13:12]};
      wr_reg(8'h07, rv[7:0]);
      rd_reg(8'h07, d);
      chk("masks", mask_v, d);
      if (i < 6) begin
        run(tt[i], tr[i], ts[i], 1'b0);
      end else begin
        run(int'(xs() % 3400), int'(xs() % 3400), int'(xs() % 3400), 1'b0);
      end
    end
    $display("test detections done");
    complete_run();
  end
endmodule // hdrs_status_tb_top

`default_nettype wire
